// ==== sync_route.v ====
// Trigger routing between modulator, timer channels and two converters
// Assumes all sources run on clk; selects and modes come from a
// system control register outside this block
`timescale 1ns/1ps
`default_nettype none
`include "sync_route_consts.vh"
module sync_route #(
    parameter PAIRS = `PAIR_COUNT
) (
    input  wire                 clk,
    input  wire                 resetn,
    input  wire                 pwm_reload,
    input  wire                 pwm_sync_to_timer_sel,
    input  wire                 timer3_src_in,
    output wire                 timer3_input,
    input  wire                 timer3_out,
    input  wire                 timer2_out,
    input  wire [`MODE_W-1:0]   conv_mode,
    output wire                 pwm_sync_pulse,
    output wire                 adc_sync_primary,
    output wire                 adc_sync_secondary,
    output wire                 converter_a_start,
    output wire                 converter_b_start,
    input  wire [PAIRS-1:0]     limit_src_en,
    input  wire [PAIRS-1:0]     above_high,
    input  wire [PAIRS-1:0]     below_low,
    output wire [PAIRS-1:0]     pair_active
);
    // Edge pulses from the reload and timer level inputs
    wire                reload_p;
    wire                prim_p;
    wire                sec_p;

    // Registered copies of every output except pair_active, and their next values
    reg                 pwm_sync_pulse_q;
    reg                 pwm_sync_pulse_d;
    reg                 timer3_input_q;
    reg                 timer3_input_d;
    reg                 adc_sync_primary_q;
    reg                 adc_sync_primary_d;
    reg                 adc_sync_secondary_q;
    reg                 adc_sync_secondary_d;
    reg                 converter_a_start_q;
    reg                 converter_a_start_d;
    reg                 converter_b_start_q;
    reg                 converter_b_start_d;

    // Modes in which the primary sync starts both converters
    function is_joint_mode;
        input [`MODE_W-1:0] m;
        begin
            is_joint_mode = (m == `MODE_SEQUENTIAL) ||
                            (m == `MODE_SIMUL_PAR);
        end
    endfunction

    // Mode in which the secondary sync starts converter B
    function is_indep_mode;
        input [`MODE_W-1:0] m;
        begin
            is_indep_mode = (m == `MODE_INDEP_PAR);
        end
    endfunction

    // Limit action of one pair; the high limit wins over the low
    function [`LIM_W-1:0] limit_action;
        input en;
        input hi;
        input lo;
        begin
            if (!en) begin
                limit_action = `LIM_KEEP;
            end else if (hi) begin
                limit_action = `LIM_DEACTIVATE;
            end else if (lo) begin
                limit_action = `LIM_ACTIVATE;
            end else begin
                limit_action = `LIM_KEEP;
            end
        end
    endfunction

    // Rising edges of the reload and timer outputs
    edge_pulse u_reload (
        .clk       (clk),
        .resetn    (resetn),
        .level_in  (pwm_reload),
        .pulse_out (reload_p)
    );

    edge_pulse u_prim (
        .clk       (clk),
        .resetn    (resetn),
        .level_in  (timer3_out),
        .pulse_out (prim_p)
    );

    edge_pulse u_sec (
        .clk       (clk),
        .resetn    (resetn),
        .level_in  (timer2_out),
        .pulse_out (sec_p)
    );

    // Reload sync and timer channel 3 input selection
    always @* begin
        pwm_sync_pulse_d = reload_p;
        if (pwm_sync_to_timer_sel) begin
            timer3_input_d = reload_p;
        end else begin
            timer3_input_d = timer3_src_in;
        end
    end

    // Converter sync copies of the timer outputs
    always @* begin
        adc_sync_primary_d   = timer3_out;
        adc_sync_secondary_d = timer2_out;
    end

    // Converter start pulses by conversion mode
    always @* begin
        converter_a_start_d = prim_p;
        converter_b_start_d = 1'h0;
        if (is_joint_mode(conv_mode)) begin
            converter_b_start_d = prim_p;
        end else if (is_indep_mode(conv_mode)) begin
            converter_b_start_d = sec_p;
        end
    end

    // Sync pulse and channel 3 input registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_sync_pulse_q <= 1'h0;
            timer3_input_q   <= 1'h0;
        end else begin
            pwm_sync_pulse_q <= pwm_sync_pulse_d;
            timer3_input_q   <= timer3_input_d;
        end
    end

    // Converter sync registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adc_sync_primary_q   <= 1'h0;
            adc_sync_secondary_q <= 1'h0;
        end else begin
            adc_sync_primary_q   <= adc_sync_primary_d;
            adc_sync_secondary_q <= adc_sync_secondary_d;
        end
    end

    // Converter start registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            converter_a_start_q <= 1'h0;
            converter_b_start_q <= 1'h0;
        end else begin
            converter_a_start_q <= converter_a_start_d;
            converter_b_start_q <= converter_b_start_d;
        end
    end

    // Outputs come straight from the flip-flops
    assign pwm_sync_pulse     = pwm_sync_pulse_q;
    assign timer3_input       = timer3_input_q;
    assign adc_sync_primary   = adc_sync_primary_q;
    assign adc_sync_secondary = adc_sync_secondary_q;
    assign converter_a_start  = converter_a_start_q;
    assign converter_b_start  = converter_b_start_q;

    // One limit-driven output state per pair
    genvar g;
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : g_pair
            reg                 act_q;
            reg                 act_d;
            wire [`LIM_W-1:0]   action;

            assign action = limit_action(limit_src_en[g],
                                         above_high[g],
                                         below_low[g]);

            always @* begin
                case (action)
                    `LIM_ACTIVATE: begin
                        act_d = 1'h1;
                    end
                    `LIM_DEACTIVATE: begin
                        act_d = 1'h0;
                    end
                    default: begin
                        act_d = act_q;
                    end
                endcase
            end

            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    act_q <= 1'h0;
                end else begin
                    act_q <= act_d;
                end
            end

            assign pair_active[g] = act_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== sync_route_consts.vh ====
// Constants for the converter trigger routing block
// Assumes inclusion by bare name from the routing design files
`ifndef SYNC_ROUTE_CONSTS_VH
`define SYNC_ROUTE_CONSTS_VH
// Conversion modes
`define MODE_W          2
`define MODE_SEQUENTIAL 2'h0
`define MODE_SIMUL_PAR  2'h1
`define MODE_INDEP_PAR  2'h2
// Limit action encodings
`define LIM_W           2
`define LIM_KEEP        2'h0
`define LIM_ACTIVATE    2'h1
`define LIM_DEACTIVATE  2'h2
// Number of modulator pairs
`define PAIR_COUNT      3
`endif

// ==== edge_pulse.v ====
// Rising edge to one-cycle pulse on the block clock
// Assumes the input comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module edge_pulse (
    input  wire clk,
    input  wire resetn,
    input  wire level_in,
    output wire pulse_out
);
    reg prev_q;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_in;
        end
    end

    assign pulse_out = level_in & ~prev_q;
endmodule
`default_nettype wire

// ==== sync_route_sva.sv ====
// Checker on routing block ports
// Assumes bind to sync_route
`timescale 1ns/1ps
`default_nettype none
module sync_route_sva #(parameter PAIRS = 3) (
    input wire logic clk, resetn, pwm_reload, pwm_sync_to_timer_sel,
    input wire logic timer3_src_in, timer3_input, timer3_out, timer2_out,
    input wire logic pwm_sync_pulse, adc_sync_primary, adc_sync_secondary,
    input wire logic converter_a_start, converter_b_start,
    input wire logic [1:0] conv_mode,
    input wire logic [PAIRS-1:0] limit_src_en, above_high, pair_active);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    reload_pulse_a: assert property ($rose(pwm_reload) |=>
        pwm_sync_pulse ##1 !pwm_sync_pulse) else $error("pulse");
    sync_route_a: assert property (pwm_sync_to_timer_sel |=>
        timer3_input == pwm_sync_pulse) else $error("route");
    plain_src_a: assert property (!pwm_sync_to_timer_sel |=>
        timer3_input == $past(timer3_src_in)) else $error("src");
    prim_sync_a: assert property (resetn |=>
        adc_sync_primary == $past(timer3_out)) else $error("prim");
    sec_sync_a: assert property (resetn |=>
        adc_sync_secondary == $past(timer2_out)) else $error("sec");
    both_start_a: assert property ($rose(timer3_out) && !conv_mode[1]
        |=> converter_a_start && converter_b_start) else $error("ab");
    b_indep_a: assert property (conv_mode == 2'h2 |=>
        converter_b_start == $rose(adc_sync_secondary)) else $error("b");
    limit_off_a: assert property (limit_src_en[0] && above_high[0]
        |-> ##[0:2] !pair_active[0]) else $error("limit");
    cover property (pwm_sync_to_timer_sel && timer3_input);
    cover property (conv_mode == 2'h2 && converter_b_start);
    cover property (pair_active[0]);
endmodule
bind sync_route sync_route_sva #(.PAIRS(PAIRS)) sync_route_sva_inst (.*);
`default_nettype wire

// ==== timer_model.sv ====
// Timer stand-in: channel 3 echoes its input, channel 2 a strobe
// Assumes the routing block's clock and reset
`timescale 1ns/1ps
`default_nettype none
module timer_model (
    input wire logic clk, resetn, timer3_input, timer2_go,
    output logic timer3_out, timer2_out);
    always @(posedge clk or negedge resetn)
        if (!resetn) {timer3_out, timer2_out} <= 2'h0;
        else {timer3_out, timer2_out} <= {timer3_input, timer2_go};
endmodule
`default_nettype wire

// ==== test_adc_pwm_sync_routing.sv ====
// Bench for the routing block through a timer stand-in
// Assumes design, timer model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module test_adc_pwm_sync_routing;
    logic clk = 1'h0, resetn = 1'h0, pwm_reload = 1'h0, timer2_go = 1'h0;
    logic pwm_sync_to_timer_sel = 1'h0, timer3_src_in = 1'h0, timer3_input;
    logic timer3_out, timer2_out, pwm_sync_pulse, adc_sync_primary;
    logic adc_sync_secondary, converter_a_start, converter_b_start;
    logic [1:0] conv_mode = 2'h0;
    logic [2:0] limit_src_en = 3'h7, above_high = 3'h0, below_low = 3'h0;
    logic [2:0] pair_active;
    wire logic [3:0] trig = {adc_sync_primary, adc_sync_secondary,
                             converter_a_start, converter_b_start};
    int failures = 0, total_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    sync_route sync_route_inst (.*);
    timer_model timer_model_inst (.*);
    task chk(input logic [3:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task mode_run(input logic [1:0] m);
        @(posedge clk) {conv_mode, timer2_go, pwm_reload} <= {m, m == 2'h2, 1'h1};
        @(posedge clk);
        @(negedge clk);
        chk({2'h0, pwm_sync_pulse, timer3_input}, 4'h3);
        @(posedge clk);
        @(negedge clk);
        chk(trig, {1'h0, m == 2'h2, 1'h0, m == 2'h2});
        @(posedge clk);
        @(negedge clk) chk(trig, {1'h1, m == 2'h2, 1'h1, m < 2'h2});
        @(posedge clk) {timer2_go, pwm_reload} <= 2'h0;
        repeat (4) @(posedge clk);
    endtask
    task plain_run;
        @(posedge clk) {pwm_reload, timer3_src_in} <= 2'h2;
        @(posedge clk);
        @(negedge clk);
        chk({2'h0, pwm_sync_pulse, timer3_input}, 4'h2);
        @(posedge clk) {pwm_reload, timer3_src_in} <= 2'h1;
        @(posedge clk);
        @(negedge clk);
        chk({2'h0, pwm_sync_pulse, timer3_input}, 4'h1);
        @(posedge clk) timer3_src_in <= 1'h0;
    endtask
    task limit_step(input logic [2:0] hi, lo, exp);
        @(posedge clk) {above_high, below_low} <= {hi, lo};
        repeat (3) @(posedge clk);
        @(negedge clk) chk(pair_active, exp);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        {resetn, pwm_sync_to_timer_sel} <= 2'h3;
        for (int m = 0; m < 4; m++) mode_run(m[1:0]);
        pwm_sync_to_timer_sel <= 1'h0;
        limit_step(3'h4, 3'h5, 3'h1);
        limit_step(3'h1, 3'h5, 3'h4);
        plain_run();
        summarize();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            summarize();
        end
    end
endmodule
`default_nettype wire
